// *** aqc_defines.svh ***
`ifndef AQC_DEFINES_SVH
`define AQC_DEFINES_SVH
`define AQC_SYS_CLK_HZ      50000000
`define AQC_CONV_CLK_HZ     1250000
`define AQC_CLK_DIV         (`AQC_SYS_CLK_HZ / `AQC_CONV_CLK_HZ / 2)
`define AQC_RESULT_BITS     12
`define AQC_CTRL_BITS       13
`define AQC_DAC_BITS        8
`define AQC_RANGE_BITS      2
`define AQC_MUX_BITS        3
`define AQC_DAC_LSB         5
`define AQC_RANGE_LSB       3
`define AQC_MUX_LSB         0
`define AQC_CONV_CYCLES     16
`endif

// *** aqc_pkg.sv ***
package aqc_pkg;
   typedef enum logic [2:0] {
      AQC_IDLE  = 3'b001,
      AQC_START = 3'b010,
      AQC_SHIFT = 3'b100
   } aqc_state_t;
endpackage

// *** aqc_link_if.sv ***
`timescale 1ns/1ps
interface aqc_link_if;
   logic converter_clock;
   logic conversion_start_n;
   logic position_sample_hold;
   logic serial_control_in;
   logic conversion_busy_n;
   logic converter2_serial_out;
   logic phase_u_current_sign;
   logic phase_u_overcurrent_n;
   modport device (input converter_clock, conversion_start_n, position_sample_hold, serial_control_in,
                   output conversion_busy_n, converter2_serial_out, phase_u_current_sign, phase_u_overcurrent_n);
   modport ctrl (output converter_clock, conversion_start_n, position_sample_hold, serial_control_in,
                 input conversion_busy_n, converter2_serial_out, phase_u_current_sign, phase_u_overcurrent_n);
endinterface

// *** aqc_device.sv ***
`timescale 1ns/1ps
`include "aqc_defines.svh"
module aqc_device #(
   parameter int RESULT_BITS = `AQC_RESULT_BITS,
   parameter int CTRL_BITS   = `AQC_CTRL_BITS
) (
   input  wire logic                   sys_clk,
   input  wire logic                   rst,
   aqc_link_if.device                  link,
   input  wire logic [RESULT_BITS-1:0] sample_result,
   input  wire logic [RESULT_BITS-1:0] phase_u_diff,
   input  wire logic                   phase_u_current_pos,
   input  wire logic                   phase_u_current_neg,
   input  wire logic [RESULT_BITS-1:0] position_sensor,
   output logic [`AQC_DAC_BITS-1:0]    dac_limit,
   output logic [`AQC_RANGE_BITS-1:0]  input_range,
   output logic [`AQC_MUX_BITS-1:0]    input_mux,
   output logic                        position_tracking,
   output logic [RESULT_BITS-1:0]      position_sample,
   output logic [RESULT_BITS-1:0]      held_result
);
   localparam logic [4:0] CNT_LAST = 5'(`AQC_CONV_CYCLES - 1);
   localparam logic [4:0] CNT_CTRL = 5'(CTRL_BITS);

   aqc_pkg::aqc_state_t           state_q;
   aqc_pkg::aqc_state_t           state_d;
   logic                          clk_prev_q;
   logic                          rise;
   logic                          shift_en;
   logic                          start_take;
   logic                          conv_last;
   logic                          ctrl_en;
   logic [RESULT_BITS-1:0]        shift_q;
   logic [CTRL_BITS-1:0]          ctrl_q;
   logic [4:0]                    cnt_q;
   logic                          busy_n_q;
   logic                          sout_q;
   logic                          sign_q;
   logic                          ovc_n_q;
   logic signed [RESULT_BITS-1:0] diff_s;
   logic signed [RESULT_BITS-1:0] lim_s;
   logic                          over_pos;
   logic                          over_neg;

   // Link pins are synchronous to sys_clk; converter clock edges become enables
   assign rise       = link.converter_clock & ~clk_prev_q;
   assign shift_en   = rise && (state_q == aqc_pkg::AQC_SHIFT);
   // A start held low during a conversion is ignored until the device is idle again
   assign start_take = rise && (state_q == aqc_pkg::AQC_IDLE) && !link.conversion_start_n;
   assign conv_last  = shift_en && (cnt_q == CNT_LAST);
   assign ctrl_en    = shift_en && (cnt_q < CNT_CTRL);

   // Limit is the DAC code widened; the window is symmetric about zero
   assign diff_s     = phase_u_diff;
   assign lim_s      = $signed({{(RESULT_BITS-`AQC_DAC_BITS){1'b0}}, dac_limit});
   assign over_pos   = diff_s > lim_s;
   assign over_neg   = diff_s < -lim_s;

   // Any unlisted state returns to idle at the next converter rise
   always_comb begin
      state_d = state_q;
      case (state_q)
         aqc_pkg::AQC_IDLE: begin
            if (start_take) begin
               state_d = aqc_pkg::AQC_SHIFT;
            end
         end
         aqc_pkg::AQC_SHIFT: begin
            if (conv_last) begin
               state_d = aqc_pkg::AQC_IDLE;
            end
         end
         default: begin
            state_d = aqc_pkg::AQC_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         clk_prev_q <= 1'b0;
      end else begin
         clk_prev_q <= link.converter_clock;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_q <= aqc_pkg::AQC_IDLE;
      end else if (rise) begin
         state_q <= state_d;
      end
   end

   // The count runs on past the control word to the last rise, so every conversion has one length
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 5'h00;
      end else if (start_take) begin
         cnt_q <= 5'h00;
      end else if (shift_en) begin
         cnt_q <= cnt_q + 5'h01;
      end
   end

   // Result leaves MSB first, one bit per converter rise
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         shift_q <= '0;
      end else if (start_take) begin
         shift_q <= sample_result;
      end else if (shift_en) begin
         shift_q <= {shift_q[RESULT_BITS-2:0], 1'b0};
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sout_q <= 1'b0;
      end else if (shift_en) begin
         sout_q <= shift_q[RESULT_BITS-1];
      end
   end

   // Only the first CTRL_BITS rises shift; the pin is ignored for the rest of the conversion
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctrl_q <= '0;
      end else if (ctrl_en) begin
         ctrl_q <= {ctrl_q[CTRL_BITS-2:0], link.serial_control_in};
      end
   end

   // A corrupted state frees the link instead of leaving busy stuck low
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         busy_n_q <= 1'b1;
      end else if (start_take) begin
         busy_n_q <= 1'b0;
      end else if (conv_last || (rise && state_q != aqc_pkg::AQC_SHIFT)) begin
         busy_n_q <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         held_result <= '0;
      end else if (start_take) begin
         held_result <= sample_result;
      end
   end

   // New settings apply once a whole word has arrived at the end of a conversion
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         dac_limit   <= '0;
         input_range <= '0;
         input_mux   <= '0;
      end else if (conv_last) begin
         dac_limit   <= ctrl_q[`AQC_DAC_LSB +: `AQC_DAC_BITS];
         input_range <= ctrl_q[`AQC_RANGE_LSB +: `AQC_RANGE_BITS];
         input_mux   <= ctrl_q[`AQC_MUX_LSB +: `AQC_MUX_BITS];
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         position_tracking <= 1'b1;
      end else begin
         position_tracking <= link.position_sample_hold;
      end
   end

   // Hold keeps the last value tracked while the pin was high
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         position_sample <= '0;
      end else if (link.position_sample_hold) begin
         position_sample <= position_sensor;
      end
   end

   // Equal inputs keep the last sign rather than toggling on noise
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sign_q <= 1'b0;
      end else if (phase_u_current_pos && !phase_u_current_neg) begin
         sign_q <= 1'b1;
      end else if (!phase_u_current_pos && phase_u_current_neg) begin
         sign_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ovc_n_q <= 1'b1;
      end else if (over_pos || over_neg) begin
         ovc_n_q <= 1'b0;
      end else begin
         ovc_n_q <= 1'b1;
      end
   end

   assign link.conversion_busy_n     = busy_n_q;
   assign link.converter2_serial_out = sout_q;
   assign link.phase_u_current_sign  = sign_q;
   assign link.phase_u_overcurrent_n = ovc_n_q;
endmodule

// *** aqc_ctrl.sv ***
`timescale 1ns/1ps
`include "aqc_defines.svh"
module aqc_ctrl #(
   parameter int RESULT_BITS = `AQC_RESULT_BITS,
   parameter int CTRL_BITS   = `AQC_CTRL_BITS,
   parameter int CLK_DIV     = `AQC_CLK_DIV
) (
   input  wire logic                   sys_clk,
   input  wire logic                   rst,
   aqc_link_if.ctrl                    link,
   input  wire logic                   start_req,
   input  wire logic [CTRL_BITS-1:0]   ctrl_word,
   input  wire logic                   track_req,
   output logic [RESULT_BITS-1:0]      result,
   output logic                        result_valid,
   output logic                        busy,
   output logic                        overcurrent,
   output logic                        current_sign
);
   aqc_pkg::aqc_state_t    state_q;
   logic [7:0]             div_q;
   logic                   cclk_q;
   logic                   start_n_q;
   logic                   sin_q;
   logic                   psh_q;
   logic [CTRL_BITS-1:0]   word_q;
   logic [RESULT_BITS-1:0] rx_q;
   logic [4:0]             cnt_q;
   logic                   fall;
   logic                   rise;

   assign rise = (div_q == 8'(CLK_DIV - 1)) && !cclk_q;
   assign fall = (div_q == 8'(CLK_DIV - 1)) && cclk_q;

   // Free-running divider: the clock never stops between conversions
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         div_q  <= 8'h00;
         cclk_q <= 1'b0;
      end else if (div_q == 8'(CLK_DIV - 1)) begin
         div_q  <= 8'h00;
         cclk_q <= ~cclk_q;
      end else begin
         div_q <= div_q + 8'h01;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         psh_q <= 1'b1;
      end else begin
         psh_q <= track_req;
      end
   end

   // Pins change on falling converter edges so they are stable at the rising edge
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_q      <= aqc_pkg::AQC_IDLE;
         start_n_q    <= 1'b1;
         sin_q        <= 1'b0;
         word_q       <= '0;
         rx_q         <= '0;
         cnt_q        <= 5'h00;
         result       <= '0;
         result_valid <= 1'b0;
         busy         <= 1'b0;
      end else begin
         result_valid <= 1'b0;
         case (state_q)
            aqc_pkg::AQC_IDLE: begin
               if (fall && start_req) begin
                  start_n_q <= 1'b0;
                  word_q    <= ctrl_word;
                  busy      <= 1'b1;
                  state_q   <= aqc_pkg::AQC_START;
               end
            end
            aqc_pkg::AQC_START: begin
               if (fall && !link.conversion_busy_n) begin
                  start_n_q <= 1'b1;
                  sin_q     <= word_q[CTRL_BITS-1];
                  word_q    <= {word_q[CTRL_BITS-2:0], 1'b0};
                  cnt_q     <= 5'h00;
                  state_q   <= aqc_pkg::AQC_SHIFT;
               end
            end
            aqc_pkg::AQC_SHIFT: begin
               if (fall) begin
                  sin_q  <= word_q[CTRL_BITS-1];
                  word_q <= {word_q[CTRL_BITS-2:0], 1'b0};
               end
               if (rise) begin
                  // Sample the bit the device shifted out at the previous rise, one sys_clk short of a full converter period earlier
                  if (cnt_q > 5'h00 && cnt_q <= 5'(RESULT_BITS)) begin
                     rx_q <= {rx_q[RESULT_BITS-2:0], link.converter2_serial_out};
                  end
                  cnt_q <= cnt_q + 5'h01;
               end
               if (link.conversion_busy_n && cnt_q > 5'(RESULT_BITS)) begin
                  result       <= rx_q;
                  result_valid <= 1'b1;
                  busy         <= 1'b0;
                  state_q      <= aqc_pkg::AQC_IDLE;
               end
            end
            default: begin
               state_q   <= aqc_pkg::AQC_IDLE;
               start_n_q <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         overcurrent  <= 1'b0;
         current_sign <= 1'b0;
      end else begin
         overcurrent  <= ~link.phase_u_overcurrent_n;
         current_sign <= link.phase_u_current_sign;
      end
   end

   assign link.converter_clock      = cclk_q;
   assign link.conversion_start_n   = start_n_q;
   assign link.position_sample_hold = psh_q;
   assign link.serial_control_in    = sin_q;
endmodule

// *** aqc_link_chk.sv ***
`timescale 1ns/1ps
module aqc_link_chk (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic converter_clock,
   input wire logic conversion_start_n,
   input wire logic position_sample_hold,
   input wire logic serial_control_in,
   input wire logic conversion_busy_n,
   input wire logic converter2_serial_out,
   input wire logic phase_u_current_sign,
   input wire logic phase_u_overcurrent_n
);
   logic       clk_q;
   logic       seen_q;
   logic [4:0] rcnt_q;
   logic [5:0] hcnt_q;
   wire        rise = converter_clock & ~clk_q;
   wire        chg  = converter_clock ^ clk_q;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Rises counted only while busy, so the count at release is the conversion length
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         clk_q <= 1'b0;
         seen_q <= 1'b0;
         rcnt_q <= 5'h0;
         hcnt_q <= 6'h0;
      end else begin
         clk_q <= converter_clock;
         seen_q <= seen_q | chg;
         rcnt_q <= conversion_busy_n ? 5'h0 : rcnt_q + {4'h0, rise};
         hcnt_q <= chg ? 6'h0 : hcnt_q + 6'h1;
      end
   end
   chk_start_taken: assert property (rise && !conversion_start_n && conversion_busy_n |=> !conversion_busy_n)
      else $error("start seen but busy not driven");
   chk_busy_cause: assert property ($fell(conversion_busy_n) |-> $past(rise) && !$past(conversion_start_n))
      else $error("busy without start");
   chk_start_release: assert property ($rose(conversion_start_n) |-> !conversion_busy_n)
      else $error("start released before busy");
   chk_busy_length: assert property ($rose(conversion_busy_n) |-> rcnt_q == 5'h10)
      else $error("busy length wrong");
   chk_busy_bound: assert property (!conversion_busy_n |-> rcnt_q <= 5'h10)
      else $error("busy too long");
   chk_clk_half: assert property (chg && seen_q |-> hcnt_q == 6'h13)
      else $error("converter clock half period wrong");
   chk_sout_edge: assert property ($changed(converter2_serial_out) |-> $past(rise))
      else $error("serial out changed off a rise");
   chk_sin_edge: assert property ($changed(serial_control_in) |-> !$past(rise))
      else $error("serial in changed at a rise");
   cover property ($rose(conversion_busy_n));
   cover property ($fell(phase_u_overcurrent_n));
   cover property ($rose(phase_u_current_sign) && position_sample_hold);
endmodule

// *** acquisition_conversion_control_bench.sv ***
`timescale 1ns/1ps
module acquisition_conversion_control_bench;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic        start_req = 1'b0;
   logic        track_req = 1'b1;
   logic        pos = 1'b0;
   logic        neg = 1'b0;
   logic [12:0] ctrl_word = 13'h0;
   logic [11:0] sample_result = 12'h0;
   logic [11:0] phase_u_diff = 12'h0;
   logic [11:0] position_sensor = 12'h0;
   logic [11:0] position_sample;
   logic [11:0] result, held_result;
   logic        result_valid, busy, overcurrent, current_sign, position_tracking;
   logic [7:0]  dac_limit;
   logic [1:0]  input_range;
   logic [2:0]  input_mux;
   logic [11:0] diffs [3] = '{12'h100, 12'hf00, 12'h010};
   int          bad_count = 0;
   int          total_checks = 0;
   aqc_link_if link_if ();
   aqc_device aqc_device_inst (.sys_clk(sys_clk), .rst(rst), .link(link_if), .sample_result(sample_result),
      .phase_u_diff(phase_u_diff), .phase_u_current_pos(pos), .phase_u_current_neg(neg), .dac_limit(dac_limit),
      .input_range(input_range), .input_mux(input_mux), .position_tracking(position_tracking),
      .position_sensor(position_sensor), .position_sample(position_sample), .held_result(held_result));
   aqc_ctrl aqc_ctrl_inst (.sys_clk(sys_clk), .rst(rst), .link(link_if), .start_req(start_req),
      .ctrl_word(ctrl_word), .track_req(track_req), .result(result), .result_valid(result_valid), .busy(busy),
      .overcurrent(overcurrent), .current_sign(current_sign));
   aqc_link_chk aqc_link_chk_inst (.sys_clk(sys_clk), .rst(rst), .converter_clock(link_if.converter_clock),
      .conversion_start_n(link_if.conversion_start_n), .position_sample_hold(link_if.position_sample_hold),
      .serial_control_in(link_if.serial_control_in), .conversion_busy_n(link_if.conversion_busy_n),
      .converter2_serial_out(link_if.converter2_serial_out), .phase_u_current_sign(link_if.phase_u_current_sign),
      .phase_u_overcurrent_n(link_if.phase_u_overcurrent_n));
   initial begin
      forever #10 sys_clk = ~sys_clk;
   end
   task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Start is held until busy shows, since it is only taken on a converter clock phase
   task automatic test_conv(input logic [12:0] w, input logic [11:0] s);
      int n;
      n = 0;
      @(posedge sys_clk);
      ctrl_word <= w;
      sample_result <= s;
      start_req <= 1'b1;
      while (n < 3000) begin
         @(posedge sys_clk);
         if (busy === 1'b1) start_req <= 1'b0;
         #1;
         if (result_valid === 1'b1) break;
         n++;
      end
      if (n >= 3000) begin
         bad_count++;
         summarize();
      end
      check("result", result, s);
      check("held", held_result, s);
      check("dac", 12'(dac_limit), 12'(w[12:5]));
      check("range", 12'(input_range), 12'(w[4:3]));
      check("mux", 12'(input_mux), 12'(w[2:0]));
      $display("conversion test done");
   endtask
   task automatic test_track;
      for (int i = 0; i < 2; i++) begin
         @(posedge sys_clk);
         track_req <= i[0];
         position_sensor <= 12'h5a0;
         repeat (4) @(posedge sys_clk);
         position_sensor <= 12'h0c3;
         repeat (4) @(posedge sys_clk);
         #1;
         check("sample hold", 12'(link_if.position_sample_hold), 12'(i[0]));
         check("tracking", 12'(position_tracking), 12'(i[0]));
         check("position", position_sample, i[0] ? 12'h0c3 : 12'h5a0);
      end
      $display("track test done");
   endtask
   task automatic test_comp;
      for (int i = 0; i < 3; i++) begin
         @(posedge sys_clk);
         pos <= (i != 1);
         neg <= (i == 1);
         phase_u_diff <= diffs[i];
         repeat (8) @(posedge sys_clk);
         #1;
         check("sign", 12'(link_if.phase_u_current_sign), 12'(i != 1));
         check("over_n", 12'(link_if.phase_u_overcurrent_n), 12'(i == 2));
         check("ctrl sign", 12'(current_sign), 12'(i != 1));
         check("ctrl over", 12'(overcurrent), 12'(i != 2));
      end
      $display("comparator test done");
   endtask
   initial begin
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      test_conv({8'h3c, 2'h2, 3'h5}, 12'ha5c);
      test_conv({8'hc3, 2'h1, 3'h2}, 12'h3a6);
      test_track();
      test_comp();
      summarize();
   end
endmodule
